// ===== hdl/urb_receiver.sv
// Serial receiver with two-entry buffer, error flags and AXI4-Lite registers
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module urb_receiver
#(
   parameter logic [15:0] BAUD_DIV_RESET = 16'h0000
)
(
   // Clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // AXI4-Lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   // AXI4-Lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // AXI4-Lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   // AXI4-Lite read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Serial line and pin control
   input  wire logic        rxd,
   output logic             rx_pin_override,
   // Interrupt
   input  wire logic        global_int_enable,
   output logic             rx_int_req
);

   typedef struct packed {
      logic                  sync1;
      logic                  sync2;
      logic                  prev;
      urb_pkg::urb_state_type st;
      logic [15:0]           baud_cnt;
      logic [3:0]            samp;
      logic [2:0]            votes;
      logic [3:0]            bit_idx;
      logic [8:0]            shift;
      logic                  par_bit;
      logic                  fr_par_en;
      logic                  fr_par_odd;
      logic                  pend_valid;
      urb_pkg::urb_entry_type pend;
      urb_pkg::urb_entry_type [1:0] fifo;
      logic                  rd_ptr;
      logic                  wr_ptr;
      logic [1:0]            count;
      logic                  overrun;
      logic                  rx_en;
      logic                  rx_int_en;
      logic                  dbl_speed;
      logic                  par_en;
      logic                  par_odd;
      logic                  two_stop;
      logic [2:0]            csize;
      logic [15:0]           baud_div;
      logic                  irq;
      logic                  awready;
      logic                  wready;
      logic                  aw_have;
      logic                  w_have;
      logic [7:0]            aw_addr;
      logic [31:0]           wdat;
      logic [3:0]            wstb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
   } urb_regs_type;

   localparam urb_regs_type RESET_STATE = '{
      sync1: 1'b1, sync2: 1'b1, prev: 1'b1,
      st: urb_pkg::ST_IDLE,
      baud_cnt: 16'h0000, samp: 4'h0, votes: 3'h0, bit_idx: 4'h0,
      shift: 9'h000, par_bit: 1'b0, fr_par_en: 1'b0, fr_par_odd: 1'b0,
      pend_valid: 1'b0, pend: '0, fifo: '0,
      rd_ptr: 1'b0, wr_ptr: 1'b0, count: 2'h0, overrun: 1'b0,
      rx_en: 1'b0, rx_int_en: 1'b0, dbl_speed: 1'b0,
      par_en: 1'b0, par_odd: 1'b0,
      two_stop: 1'b0, csize: urb_pkg::CSZ_RESET,
      baud_div: BAUD_DIV_RESET, irq: 1'b0,
      awready: 1'b1, wready: 1'b1, aw_have: 1'b0, w_have: 1'b0,
      aw_addr: 8'h00, wdat: 32'h0000_0000, wstb: 4'h0,
      bvalid: 1'b0, bresp: urb_pkg::RESP_OKAY,
      arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000,
      rresp: urb_pkg::RESP_OKAY
   };

   urb_regs_type s;
   urb_regs_type next_s;

   // Majority of three samples
   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   // Index of the last data bit for a character size code
   function automatic logic [3:0] last_bit(input logic [2:0] csz);
      unique case (csz)
         urb_pkg::CSZ_5: last_bit = 4'h4;
         urb_pkg::CSZ_6: last_bit = 4'h5;
         urb_pkg::CSZ_7: last_bit = 4'h6;
         urb_pkg::CSZ_9: last_bit = 4'h8;
         default:        last_bit = 4'h7;
      endcase
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == urb_pkg::OFS_DATA) || (a == urb_pkg::OFS_STATUS) ||
                (a == urb_pkg::OFS_CONTROL) || (a == urb_pkg::OFS_FORMAT) ||
                (a == urb_pkg::OFS_BAUD);
   endfunction

   always_comb
   begin
      logic                   line;
      logic                   tick;
      logic [3:0]             samp_last;
      logic [3:0]             vote_first;
      logic                   vote_now;
      logic                   decide;
      logic                   bitval;
      logic                   mismatch;
      urb_pkg::urb_entry_type head;
      urb_pkg::urb_entry_type done;
      logic                   done_valid;
      logic                   ovr_set;
      logic [31:0]            rd;
      line       = s.sync2;
      tick       = 1'b0;
      samp_last  = urb_pkg::NORM_LAST;
      vote_first = urb_pkg::NORM_VOTE;
      vote_now   = 1'b0;
      decide     = 1'b0;
      bitval     = 1'b0;
      mismatch   = 1'b0;
      head       = s.fifo[s.rd_ptr];
      done       = '0;
      done_valid = 1'b0;
      ovr_set    = 1'b0;
      rd         = 32'h0000_0000;
      next_s     = s;

      // Second flop only feeds the logic
      next_s.sync1 = rxd;
      next_s.sync2 = s.sync1;

      // Write channels taken independently
      if (awvalid && s.awready)
      begin
         next_s.aw_have = 1'b1;
         next_s.aw_addr = awaddr;
         next_s.awready = 1'b0;
      end
      if (wvalid && s.wready)
      begin
         next_s.w_have = 1'b1;
         next_s.wdat   = wdata;
         next_s.wstb   = wstrb;
         next_s.wready = 1'b0;
      end
      if (s.aw_have && s.w_have && !s.bvalid)
      begin
         next_s.aw_have = 1'b0;
         next_s.w_have  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = addr_ok(s.aw_addr) ? urb_pkg::RESP_OKAY
                                             : urb_pkg::RESP_SLVERR;
         if (s.wstb[0])
         begin
            unique case (s.aw_addr)
               urb_pkg::OFS_STATUS:
                  next_s.dbl_speed = s.wdat[urb_pkg::ST_DBL_SPEED];
               urb_pkg::OFS_CONTROL:
               begin
                  next_s.rx_int_en = s.wdat[urb_pkg::CT_RX_INT_EN];
                  next_s.rx_en     = s.wdat[urb_pkg::CT_RX_EN];
               end
               urb_pkg::OFS_FORMAT:
               begin
                  next_s.par_en   = s.wdat[urb_pkg::FM_PAR_EN];
                  next_s.par_odd  = s.wdat[urb_pkg::FM_PAR_ODD];
                  next_s.two_stop = s.wdat[urb_pkg::FM_TWO_SB];
                  next_s.csize    = s.wdat[urb_pkg::FM_CSZ_LO +: 3];
               end
               urb_pkg::OFS_BAUD:
                  next_s.baud_div[7:0] = s.wdat[7:0];
               default:
                  next_s.csize = s.csize;
            endcase
         end
         if (s.wstb[1] && s.aw_addr == urb_pkg::OFS_BAUD)
            next_s.baud_div[15:8] = s.wdat[15:8];
      end
      if (s.bvalid && bready)
      begin
         next_s.bvalid  = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready  = 1'b1;
      end

      // Reads answer one cycle after the address is taken
      if (arvalid && s.arready)
      begin
         unique case (araddr)
            urb_pkg::OFS_DATA:
            begin
               if (s.count != 2'h0)
               begin
                  rd[7:0] = head.data[7:0];
                  next_s.rd_ptr = ~s.rd_ptr;
                  next_s.count  = s.count - 2'h1;
               end
            end
            urb_pkg::OFS_STATUS:
            begin
               rd[urb_pkg::ST_RXC] = (s.count != 2'h0);
               rd[urb_pkg::ST_STOP_ERR] = (s.count != 2'h0) & head.stop_err;
               rd[urb_pkg::ST_OVERRUN]  = (s.count != 2'h0) & head.overrun;
               rd[urb_pkg::ST_PAR_ERR]  = (s.count != 2'h0) & head.par_err
                                          & s.par_en;
               rd[urb_pkg::ST_DBL_SPEED] = s.dbl_speed;
            end
            urb_pkg::OFS_CONTROL:
            begin
               rd[urb_pkg::CT_RX_INT_EN] = s.rx_int_en;
               rd[urb_pkg::CT_RX_EN]     = s.rx_en;
               rd[urb_pkg::CT_NINTH]     = (s.count != 2'h0) & head.data[8];
            end
            urb_pkg::OFS_FORMAT:
            begin
               rd[urb_pkg::FM_PAR_EN]  = s.par_en;
               rd[urb_pkg::FM_PAR_ODD] = s.par_odd;
               rd[urb_pkg::FM_TWO_SB]  = s.two_stop;
               rd[urb_pkg::FM_CSZ_LO +: 3] = s.csize;
            end
            urb_pkg::OFS_BAUD:
               rd[15:0] = s.baud_div;
            default:
               rd = 32'h0000_0000;
         endcase
         next_s.arready = 1'b0;
         next_s.rvalid  = 1'b1;
         next_s.rdata   = rd;
         next_s.rresp   = addr_ok(araddr) ? urb_pkg::RESP_OKAY
                                          : urb_pkg::RESP_SLVERR;
      end
      if (s.rvalid && rready)
      begin
         next_s.rvalid  = 1'b0;
         next_s.arready = 1'b1;
      end

      if (s.dbl_speed)
      begin
         samp_last  = urb_pkg::DBL_LAST;
         vote_first = urb_pkg::DBL_VOTE;
      end

      if (!next_s.rx_en)
      begin
         next_s.st         = urb_pkg::ST_IDLE;
         next_s.count      = 2'h0;
         next_s.rd_ptr     = 1'b0;
         next_s.wr_ptr     = 1'b0;
         next_s.pend_valid = 1'b0;
         next_s.overrun    = 1'b0;
         next_s.prev       = 1'b1;
         next_s.baud_cnt   = 16'h0000;
      end
      else
      begin
         // Sample tick from the free-running baud counter; only the sample index restarts at each start edge
         tick = (s.baud_cnt == 16'h0000);
         next_s.baud_cnt = tick ? s.baud_div : s.baud_cnt - 16'h0001;
         if (tick)
         begin
            next_s.prev = line;
            vote_now = (s.samp == vote_first) ||
                       (s.samp == vote_first + 4'h1) ||
                       (s.samp == vote_first + 4'h2);
            decide   = (s.samp == vote_first + 4'h2);
            if (vote_now)
               next_s.votes = {s.votes[1:0], line};
            bitval = maj3({s.votes[1:0], line});
            next_s.samp = (s.samp == samp_last) ? 4'h0 : s.samp + 4'h1;
            unique case (s.st)
               urb_pkg::ST_IDLE:
               begin
                  if (s.prev && !line)
                  begin
                     next_s.st      = urb_pkg::ST_START;
                     next_s.samp    = 4'h1;
                     next_s.shift   = 9'h000;
                     next_s.bit_idx = 4'h0;
                     next_s.fr_par_en  = s.par_en;
                     next_s.fr_par_odd = s.par_odd;
                     if (s.count == 2'h2 && s.pend_valid)
                     begin
                        ovr_set        = 1'b1;
                        next_s.overrun = 1'b1;
                     end
                  end
                  else
                     next_s.samp = 4'h0;
               end
               urb_pkg::ST_START:
               begin
                  if (decide && bitval)
                  begin
                     next_s.st   = urb_pkg::ST_IDLE;
                     next_s.samp = 4'h0;
                  end
                  else if (s.samp == samp_last)
                     next_s.st = urb_pkg::ST_DATA;
               end
               urb_pkg::ST_DATA:
               begin
                  if (decide)
                     next_s.shift[s.bit_idx] = bitval;
                  if (s.samp == samp_last)
                  begin
                     if (s.bit_idx == last_bit(s.csize))
                        next_s.st = s.fr_par_en ? urb_pkg::ST_PARITY
                                                : urb_pkg::ST_STOP;
                     else
                        next_s.bit_idx = s.bit_idx + 4'h1;
                  end
               end
               urb_pkg::ST_PARITY:
               begin
                  if (decide)
                     next_s.par_bit = bitval;
                  if (s.samp == samp_last)
                     next_s.st = urb_pkg::ST_STOP;
               end
               urb_pkg::ST_STOP:
               begin
                  if (decide)
                  begin
                     mismatch = (^s.shift ^ s.par_bit) != s.fr_par_odd;
                     done.data = s.shift;
                     done.stop_err = ~bitval;
                     done.par_err  = s.fr_par_en & mismatch;
                     done_valid = 1'b1;
                     next_s.st   = urb_pkg::ST_IDLE;
                     next_s.samp = 4'h0;
                  end
               end
               default:
                  next_s.st = urb_pkg::ST_IDLE;
            endcase
         end

         // Waiting character moves in when a slot frees
         if (s.pend_valid && next_s.count != 2'h2)
         begin
            next_s.fifo[s.wr_ptr] = s.pend;
            next_s.fifo[s.wr_ptr].overrun = s.overrun;
            // cleared on transfer; a new overrun wins
            next_s.overrun    = ovr_set;
            next_s.wr_ptr     = ~s.wr_ptr;
            next_s.count      = next_s.count + 2'h1;
            next_s.pend_valid = 1'b0;
         end
         // Frame lost if the waiting slot is still taken
         if (done_valid && !next_s.pend_valid)
         begin
            next_s.pend       = done;
            next_s.pend_valid = 1'b1;
         end
      end

      next_s.irq = (next_s.count != 2'h0) & next_s.rx_int_en &
                   global_int_enable;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= RESET_STATE;
      else if (ce)
         s <= next_s;
   end

   assign awready         = s.awready;
   assign wready          = s.wready;
   assign bvalid          = s.bvalid;
   assign bresp           = s.bresp;
   assign arready         = s.arready;
   assign rvalid          = s.rvalid;
   assign rdata           = s.rdata;
   assign rresp           = s.rresp;
   assign rx_pin_override = s.rx_en;
   assign rx_int_req      = s.irq;

endmodule

// ===== include/urb_pkg.sv
// Constants and types for the serial receive buffer and status block
// How it works
// - Receive-complete flag is one exactly while unread characters remain buffered.
// - Clearing receiver enable empties the buffer and zeroes receive-complete.
// - Interrupt request holds while receive-complete, its enable and global enable.
// - Frame, overrun and parity flags travel with their entry in the buffer.
// - Each data read advances the buffer; software reads status first.
// - Software writes to the three error flag positions are ignored.
// - Error flags never raise an interrupt.
// - Frame error is one when the first stop bit sampled low.
// - Only the first stop bit matters; two-stop setting is ignored.
// - Overrun when start arrives with buffer full and a character waiting.
// - Overrun indication clears when a frame moves into the buffer.
// - Upper parity bit enables checking, lower one selects odd or even.
// - Parity mismatch is computed and stored with the data and stop bit.
// - Parity error only if checking was on for that frame; valid until read.
// - Parity error reads zero while checking is disabled.
// - Disabling the receiver stops it at once, dropping any frame in progress.
// - While disabled the receiver releases its override of the receive pin.
// - Sampling resyncs on each start bit; every bit is majority filtered.
// - Oversample sixteen times per bit, or eight in double-speed mode.
// - Start bit voted on samples 8-10, or 4-6 in double speed.
// - Ninth bit stored with the entry and shown in the control register.
// - Unused upper data bits of short characters read as zero.
package urb_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_DATA    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_FORMAT  = 8'h0c;
   localparam logic [7:0] OFS_BAUD    = 8'h10;

   // Status register bits
   localparam int ST_RXC  = 7;
   localparam int ST_TXE  = 5;
   localparam int ST_STOP_ERR  = 4;
   localparam int ST_OVERRUN   = 3;
   localparam int ST_PAR_ERR   = 2;
   localparam int ST_DBL_SPEED = 1;

   // Control register bits
   localparam int CT_RX_INT_EN = 7;
   localparam int CT_RX_EN     = 4;
   localparam int CT_NINTH     = 1;

   // Format register bits
   localparam int FM_PAR_EN  = 5;
   localparam int FM_PAR_ODD = 4;
   localparam int FM_TWO_SB  = 3;
   localparam int FM_CSZ_LO  = 0;

   // Character size codes
   localparam logic [2:0] CSZ_5 = 3'h0;
   localparam logic [2:0] CSZ_6 = 3'h1;
   localparam logic [2:0] CSZ_7 = 3'h2;
   localparam logic [2:0] CSZ_9 = 3'h7;
   localparam logic [2:0] CSZ_RESET = 3'h3;

   // Sample index of last sample and first voting sample, minus one
   localparam logic [3:0] NORM_LAST  = 4'hf;
   localparam logic [3:0] NORM_VOTE  = 4'h7;
   localparam logic [3:0] DBL_LAST   = 4'h7;
   localparam logic [3:0] DBL_VOTE   = 4'h3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_START  = 3'b001,
      ST_DATA   = 3'b010,
      ST_PARITY = 3'b011,
      ST_STOP   = 3'b100
   } urb_state_type;

   typedef struct packed {
      logic [8:0] data;
      logic       stop_err;
      logic       overrun;
      logic       par_err;
   } urb_entry_type;

endpackage

// ===== verif/urb_serial_src.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
module urb_serial_src
(
   // Clock and serial line
   input  wire logic aclk,
   output logic      rxd
);
   initial rxd = 1'b1;

   task automatic bit_out(input logic v, input int n);
      @(posedge aclk);
      rxd <= v;
      repeat (n - 1) @(posedge aclk);
   endtask

   // Short low spike, too brief to pass the start vote
   task automatic pulse(input int n);
      bit_out(1'b0, n);
      bit_out(1'b1, 1);
   endtask

   // Trailing high time doubles as second stop bit and idle gap
   task automatic send(input logic [8:0] ch, input int nb, bt,
                       input logic [1:0] par, input logic bad, stp);
      int i;
      bit_out(1'b0, bt);
      for (i = 0; i < nb; i++)
         bit_out(ch[i], bt);
      if (par[1])
         bit_out((^(ch & ((9'h001 << nb) - 9'h001))) ^ par[0] ^ bad, bt);
      bit_out(stp, bt);
      bit_out(1'b1, 2 * bt);
   endtask
endmodule

// ===== verif/urb_receiver_sva.sv
// Assertions on the register bus and interrupt ports of the receiver
`timescale 1ns/1ps
module urb_receiver_sva
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        awready,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   // Interrupt and pin
   input wire logic        global_int_enable,
   input wire logic        rx_int_req,
   input wire logic        rx_pin_override
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_INT_GATED: assert property (!global_int_enable |=> !rx_int_req)
      else $error("interrupt without global enable");
   AST_INT_RISE: assert property ($rose(rx_int_req) |-> rx_pin_override)
      else $error("interrupt rose while receiver off");
   AST_FLUSH: assert property (!rx_pin_override [*3] |-> !rx_int_req)
      else $error("interrupt kept after flush");
   AST_R_LAT: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   AST_R_DONE: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read not closed");
   AST_B_DONE: assert property (bvalid && bready |=> !bvalid && awready && wready)
      else $error("write not closed");
   AST_AR_BLOCK: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   AST_RD_SLVERR: assert property (arvalid && arready && araddr > 8'h13
      |=> rresp == urb_pkg::RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind urb_receiver urb_receiver_sva u_sva (.aclk, .aresetn, .awready, .wready,
   .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
   .rresp, .global_int_enable, .rx_int_req, .rx_pin_override);

// ===== verif/uart_receive_buffer_status_tb.sv
// Self-checking bench for the serial receive buffer and status block
`timescale 1ns/1ps
module uart_receive_buffer_status_tb;
   typedef struct packed {
      logic [7:0] fmt;
      logic [8:0] ch;
      logic       dbl;
      logic       bad;
      logic       stp;
      logic [7:0] st;
      logic [7:0] dat;
      logic [7:0] ctl;
   } urb_row_type;
   // Format, char, double speed, bad parity, stop, status, data, control
   urb_row_type rows [10] = '{
      '{8'h03, 9'h0a5, 1'b0, 1'b0, 1'b1, 8'h80, 8'ha5, 8'h10},
      '{8'h03, 9'h03c, 1'b0, 1'b0, 1'b0, 8'h90, 8'h3c, 8'h10},
      '{8'h23, 9'h05a, 1'b0, 1'b0, 1'b1, 8'h80, 8'h5a, 8'h10},
      '{8'h23, 9'h05a, 1'b0, 1'b1, 1'b1, 8'h84, 8'h5a, 8'h10},
      '{8'h33, 9'h071, 1'b0, 1'b1, 1'b1, 8'h84, 8'h71, 8'h10},
      '{8'h00, 9'h0f5, 1'b0, 1'b0, 1'b1, 8'h80, 8'h15, 8'h10},
      '{8'h02, 9'h0ff, 1'b0, 1'b0, 1'b1, 8'h80, 8'h7f, 8'h10},
      '{8'h0b, 9'h066, 1'b0, 1'b0, 1'b0, 8'h90, 8'h66, 8'h10},
      '{8'h07, 9'h1c3, 1'b0, 1'b0, 1'b1, 8'h80, 8'hc3, 8'h12},
      '{8'h03, 9'h081, 1'b1, 1'b0, 1'b1, 8'h82, 8'h81, 8'h10}};
   logic        aclk, aresetn, gie;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        rxd, rx_pin_override, rx_int_req;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, lr;
   int          n_fail = 0;
   int          num_checks = 0;
   int          k;

   urb_receiver DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .rxd(rxd),
      .rx_pin_override(rx_pin_override), .global_int_enable(gie),
      .rx_int_req(rx_int_req));
   urb_serial_src src (.aclk(aclk), .rxd(rxd));

   task automatic wrap_up;
      if (n_fail == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tmo(input int i);
      if (i >= 60)
      begin
         n_fail++;
         wrap_up;
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 60; i++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            lr = bresp;
            bready <= 1'b0;
            break;
         end
      end
      tmo(i);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      int i;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 60; i++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            lr = rresp;
            rready <= 1'b0;
            break;
         end
      end
      tmo(i);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      axr(a, d);
      chk(d, exp);
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial
   begin
      {aresetn, gie, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      chk(32'(rx_int_req), 32'h0);
      rchk(urb_pkg::OFS_STATUS, 32'h0);
      rchk(urb_pkg::OFS_FORMAT, 32'h03);
      axw(urb_pkg::OFS_CONTROL, 32'h10);
      chk(32'(lr), 32'(urb_pkg::RESP_OKAY));
      chk(32'(rx_pin_override), 32'h1);
      src.pulse(4);
      rchk(urb_pkg::OFS_STATUS, 32'h0);
      axw(urb_pkg::OFS_STATUS, 32'h1c);
      rchk(urb_pkg::OFS_STATUS, 32'h0);
      foreach (rows[k])
      begin
         axw(urb_pkg::OFS_FORMAT, 32'(rows[k].fmt));
         axw(urb_pkg::OFS_STATUS, rows[k].dbl ? 32'h2 : 32'h0);
         src.send(rows[k].ch, (rows[k].fmt[2:0] == 3'h7) ? 9 :
            int'(rows[k].fmt[1:0]) + 5, rows[k].dbl ? 8 : 16,
            rows[k].fmt[5:4], rows[k].bad, rows[k].stp);
         rchk(urb_pkg::OFS_STATUS, 32'(rows[k].st));
         rchk(urb_pkg::OFS_CONTROL, 32'(rows[k].ctl));
         rchk(urb_pkg::OFS_DATA, 32'(rows[k].dat));
      end
      axw(urb_pkg::OFS_STATUS, 32'h0);
      axw(urb_pkg::OFS_FORMAT, 32'h23);
      src.send(9'h011, 8, 16, 2'b10, 1'b1, 1'b1);
      axw(urb_pkg::OFS_FORMAT, 32'h03);
      rchk(urb_pkg::OFS_STATUS, 32'h80);
      rchk(urb_pkg::OFS_DATA, 32'h11);
      axw(urb_pkg::OFS_CONTROL, 32'h90);
      gie <= 1'b1;
      for (k = 0; k < 4; k++)
         src.send(9'h040 + 9'(k), 8, 16, 2'b00, 1'b0, 1'b1);
      chk(32'(rx_int_req), 32'h1);
      gie <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'(rx_int_req), 32'h0);
      gie <= 1'b1;
      rchk(urb_pkg::OFS_STATUS, 32'h80);
      rchk(urb_pkg::OFS_DATA, 32'h40);
      rchk(urb_pkg::OFS_STATUS, 32'h80);
      rchk(urb_pkg::OFS_DATA, 32'h41);
      rchk(urb_pkg::OFS_STATUS, 32'h88);
      rchk(urb_pkg::OFS_DATA, 32'h42);
      rchk(urb_pkg::OFS_STATUS, 32'h0);
      chk(32'(rx_int_req), 32'h0);
      src.send(9'h0aa, 8, 16, 2'b00, 1'b0, 1'b1);
      fork
         src.send(9'h055, 8, 16, 2'b00, 1'b0, 1'b1);
         begin
            repeat (60) @(posedge aclk);
            axw(urb_pkg::OFS_CONTROL, 32'h80);
         end
      join
      chk(32'(rx_pin_override), 32'h0);
      chk(32'(rx_int_req), 32'h0);
      rchk(urb_pkg::OFS_STATUS, 32'h0);
      axw(urb_pkg::OFS_CONTROL, 32'h90);
      rchk(urb_pkg::OFS_STATUS, 32'h0);
      axr(8'h40, rd);
      chk(rd, 32'h0);
      chk(32'(lr), 32'(urb_pkg::RESP_SLVERR));
      axw(8'h40, 32'h0);
      chk(32'(lr), 32'(urb_pkg::RESP_SLVERR));
      wrap_up;
   end
endmodule
